// *** core/prp_port.sv ***
`timescale 1ns/1ps
// Function
// - claim window accesses from core and translation unit
// - accept read, write and read-modify-write
// - single-word transfers only, no bursts
// - reads and atomic writes use all four byte lanes; plain writes use the given byte enables
// - reads return all four bytes
// - writes update only enabled bytes
// - software writes some registers as full words
// - lock is taken from the bus but never looked at; no master is kept off the port
// - user and supervisor accesses both accepted
// - never signal an access fault
// - identification registers readable and writable
// - reserved configuration read returns zero
// - reserved configuration write is discarded
// - no plain access to reserved locations; plain ones are still acked, read as zero, and plain writes strobe the units
// - each register 32 bits, own address
// - accesses stay on chip, no external cycle
module prp_port (
  // clock and reset
  input  wire logic           clk_sys,
  input  wire logic           sys_rst,
  // internal bus
  prp_bus_if.port             bus,
  // user side: write event toward the peripheral units
  output logic                wr_stb,
  output logic [8:0]          wr_idx,
  output logic [31:0]         wr_data,
  output logic [3:0]          wr_be,
  // external bus cycle request, held low
  output logic                ext_cycle
);
  import prp_pkg::*;

  // ==========================================================
  // decode
  logic        hit;
  logic        busy;
  logic [8:0]  idx;
  logic        known;
  logic [31:0] regs [NUM_REGS];
  logic [31:0] cur_word;
  logic [31:0] merged;
  logic [2:0]  sel;

  assign hit = bus.req && prp_in_window(bus.addr) && !busy;
  assign idx = prp_index(bus.addr);

  // map a word index to storage, reserved otherwise
  always_comb begin
    known = 1'b1;
    sel   = 3'h0;
    case (idx)
      IDX_VENDOR:   sel = 3'h0;
      IDX_DEVICE:   sel = 3'h1;
      IDX_REVISION: sel = 3'h2;
      IDX_CLASS:    sel = 3'h3;
      IDX_HEADER:   sel = 3'h4;
      default:      known = 1'b0;
    endcase
  end

  assign cur_word = known ? regs[sel] : ZERO_WORD;

  prp_byte_merge u_merge (
    .old_word (cur_word),
    .new_word (bus.wdata),
    .be       (bus.be),
    .merged   (merged)
  );

  // ==========================================================
  // handshake: one ack per request; busy blocks a second ack while
  // the master drops its request level
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      bus.ack <= 1'b0;
      busy    <= 1'b0;
    end else begin
      bus.ack <= hit;
      busy    <= hit || (busy && bus.req && !bus.ack);
    end
  end

  // read data: whole word always, reserved reads zero
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      bus.rdata <= ZERO_WORD;
    end else if (hit && !bus.we) begin
      bus.rdata <= cur_word;
    end
  end

  // identification storage, writable from the internal bus; the
  // privilege bit is not looked at on purpose
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      regs[0] <= RST_VENDOR;
      regs[1] <= RST_DEVICE;
      regs[2] <= RST_REVISION;
      regs[3] <= RST_CLASS;
      regs[4] <= RST_HEADER;
    end else if (hit && bus.we && known) begin
      regs[sel] <= merged;
    end
  end

  // write event to units; reserved configuration writes dropped
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      wr_stb  <= 1'b0;
      wr_idx  <= 9'h000;
      wr_data <= ZERO_WORD;
      wr_be   <= 4'h0;
    end else begin
      wr_stb <= hit && bus.we && !(bus.cfg && !known);
      if (hit && bus.we) begin
        wr_idx  <= idx;
        wr_data <= bus.wdata;
        wr_be   <= bus.be;
      end
    end
  end

  // no fault and no external cycle ever
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      bus.fault <= 1'b0;
      ext_cycle <= 1'b0;
    end else begin
      bus.fault <= 1'b0;
      ext_cycle <= 1'b0;
    end
  end
endmodule : prp_port

// *** core/prp_pkg.sv ***
package prp_pkg;

  // ==========================================================
  // address window and bus shape
  localparam logic [31:0] WIN_BASE   = 32'h0000_1000;
  localparam logic [31:0] WIN_LAST   = 32'h0000_17ff;
  localparam int          DATA_W     = 32;
  localparam int          BE_W       = 4;
  localparam int          REG_IDX_W  = 9;   // 2 KiB window / 4 bytes
  localparam logic [31:0] ZERO_WORD  = 32'h0000_0000;

  // ==========================================================
  // identification registers, word indices inside the window
  localparam logic [8:0]  IDX_VENDOR   = 9'h000;
  localparam logic [8:0]  IDX_DEVICE   = 9'h001;
  localparam logic [8:0]  IDX_REVISION = 9'h002;
  localparam logic [8:0]  IDX_CLASS    = 9'h003;
  localparam logic [8:0]  IDX_HEADER   = 9'h004;
  localparam int          NUM_REGS     = 5;
  // reset values are arbitrary, not tied to any maker
  localparam logic [31:0] RST_VENDOR   = 32'h0000_1234;
  localparam logic [31:0] RST_DEVICE   = 32'h0000_5678;
  localparam logic [31:0] RST_REVISION = 32'h0000_0001;
  localparam logic [31:0] RST_CLASS    = 32'h0000_0000;
  localparam logic [31:0] RST_HEADER   = 32'h0000_0000;

  // ==========================================================
  // masters and transfer kinds
  typedef enum logic {PRP_MST_CORE, PRP_MST_ATU} prp_mst_t;
  typedef enum logic [1:0] {
    PRP_OP_READ, PRP_OP_WRITE, PRP_OP_RMW
  } prp_op_t;

  // ==========================================================
  // true when an address hits the register window
  function automatic logic prp_in_window(input logic [31:0] a);
    return (a >= WIN_BASE) && (a <= WIN_LAST);
  endfunction : prp_in_window

  // word index inside the window
  function automatic logic [8:0] prp_index(input logic [31:0] a);
    return a[10:2];
  endfunction : prp_index

endpackage : prp_pkg

// *** core/prp_bus_if.sv ***
`timescale 1ns/1ps
// internal bus between a master and the register port
interface prp_bus_if;
  import prp_pkg::*;
  logic              req;     // request level, held until ack
  logic              we;      // write when high
  logic              lock;    // held over an atomic pair
  logic              cfg;     // configuration cycle
  logic              mst;     // 0 core, 1 translation unit
  logic              sup;     // supervisor mode, accepted either way
  logic [31:0]       addr;
  logic [3:0]        be;
  logic [31:0]       wdata;
  logic [31:0]       rdata;
  logic              ack;     // one-cycle completion pulse
  logic              fault;   // never raised by the port

  modport port (
    input  req, we, lock, cfg, mst, sup, addr, be, wdata,
    output rdata, ack, fault
  );
  modport master (
    output req, we, lock, cfg, mst, sup, addr, be, wdata,
    input  rdata, ack, fault
  );
endinterface : prp_bus_if

// *** core/prp_byte_merge.sv ***
`timescale 1ns/1ps
// merges enabled bytes of new write data into an old word
module prp_byte_merge (
  // operands
  input  wire logic [31:0] old_word,
  input  wire logic [31:0] new_word,
  input  wire logic [3:0]  be,
  // merged result
  output logic      [31:0] merged
);
  import prp_pkg::*;

  // per-lane select, lanes with be low keep their old value
  always_comb begin
    for (int i = 0; i < BE_W; i++) begin
      merged[i*8 +: 8] = be[i] ? new_word[i*8 +: 8] : old_word[i*8 +: 8];
    end
  end
endmodule : prp_byte_merge

// *** core/prp_master.sv ***
`timescale 1ns/1ps
// bus master end: issues one word transfer, or an atomic pair
module prp_master (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  // user command
  input  wire logic        cmd_valid,
  input  prp_pkg::prp_op_t cmd_op,
  input  prp_pkg::prp_mst_t cmd_mst,
  input  wire logic        cmd_cfg,
  input  wire logic        cmd_sup,
  input  wire logic [31:0] cmd_addr,
  input  wire logic [3:0]  cmd_be,
  input  wire logic [31:0] cmd_data,
  // user answer
  output logic             cmd_ready,
  output logic             rsp_valid,
  output logic [31:0]      rsp_data,
  // internal bus
  prp_bus_if.master        bus
);
  import prp_pkg::*;

  typedef enum logic [1:0] {
    PRP_ST_IDLE, PRP_ST_XFER, PRP_ST_RMW_WR
  } prp_state_t;
  prp_state_t  state;
  prp_op_t     op;
  logic [31:0] wdat;

  // ==========================================================
  // sequencer; atomic op reads then writes back with lock held
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state     <= PRP_ST_IDLE;
      op        <= PRP_OP_READ;
      wdat      <= ZERO_WORD;
      bus.req   <= 1'b0;
      bus.we    <= 1'b0;
      bus.lock  <= 1'b0;
      bus.cfg   <= 1'b0;
      bus.mst   <= 1'b0;
      bus.sup   <= 1'b0;
      bus.addr  <= ZERO_WORD;
      bus.be    <= 4'h0;
      bus.wdata <= ZERO_WORD;
      cmd_ready <= 1'b1;
      rsp_valid <= 1'b0;
      rsp_data  <= ZERO_WORD;
    end else begin
      rsp_valid <= 1'b0;
      case (state)
        PRP_ST_IDLE: begin
          if (cmd_valid) begin
            state     <= PRP_ST_XFER;
            op        <= cmd_op;
            wdat      <= cmd_data;
            cmd_ready <= 1'b0;
            bus.req   <= 1'b1;
            bus.we    <= (cmd_op == PRP_OP_WRITE);
            bus.lock  <= (cmd_op == PRP_OP_RMW);
            bus.cfg   <= cmd_cfg;
            bus.mst   <= cmd_mst;
            bus.sup   <= cmd_sup;
            bus.addr  <= cmd_addr;
            // reads always ask a whole word
            bus.be    <= (cmd_op == PRP_OP_WRITE) ? cmd_be : 4'hf;
            bus.wdata <= cmd_data;
          end
        end
        PRP_ST_XFER: begin
          if (bus.ack) begin
            bus.req  <= 1'b0;
            rsp_data <= bus.rdata;
            if (op == PRP_OP_RMW) begin
              state <= PRP_ST_RMW_WR;       // lock stays high
            end else begin
              state     <= PRP_ST_IDLE;
              rsp_valid <= 1'b1;
              cmd_ready <= 1'b1;
            end
          end
        end
        PRP_ST_RMW_WR: begin
          if (!bus.req) begin
            bus.req   <= 1'b1;
            bus.we    <= 1'b1;
            bus.be    <= 4'hf;
            bus.wdata <= wdat;
          end else if (bus.ack) begin
            state     <= PRP_ST_IDLE;
            bus.req   <= 1'b0;
            bus.lock  <= 1'b0;
            rsp_valid <= 1'b1;
            cmd_ready <= 1'b1;
          end
        end
        default: state <= PRP_ST_IDLE;
      endcase
    end
  end
endmodule : prp_master

// *** verif/prp_assertions.sv ***
`timescale 1ns/1ps
// ========
// bus checker, beside the joined interface
module prp_assertions (
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        sys_rst,
  // bus
  input wire logic        req,
  input wire logic        we,
  input wire logic        lock,
  input wire logic        cfg,
  input wire logic [31:0] addr,
  input wire logic [31:0] rdata,
  input wire logic        ack,
  input wire logic        fault
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // window hit, kept apart from the design's own helper
  logic win;
  assign win = (addr >= 32'h0000_1000) && (addr <= 32'h0000_17ff);

  property p_ack_win; ack |-> $past(req && win); endproperty
  a_ack_win: assert property (p_ack_win)
    else $error("ack without a window request");
  property p_take; req && win && !ack |=> ack; endproperty
  a_take: assert property (p_take)
    else $error("window request not acked next cycle");
  property p_no_out; req && !win |=> !ack; endproperty
  a_no_out: assert property (p_no_out)
    else $error("request outside window acked");
  property p_one_ack; ack |=> !ack; endproperty
  a_one_ack: assert property (p_one_ack)
    else $error("ack longer than one cycle");
  property p_fault; !fault; endproperty
  a_fault: assert property (p_fault)
    else $error("access fault raised");
  property p_cfg0;
    ack && $past(!we && cfg && win && addr[10:2] > 9'h004)
      |-> rdata == 32'h0000_0000;
  endproperty
  a_cfg0: assert property (p_cfg0)
    else $error("reserved configuration read not zero");
  property p_lock; ack && lock && !we |=> lock [*2]; endproperty
  a_lock: assert property (p_lock)
    else $error("lock dropped inside atomic pair");
  property p_burst; ack |=> !req; endproperty
  a_burst: assert property (p_burst)
    else $error("request kept after ack");
endmodule : prp_assertions

// *** verif/testbench.sv ***
`timescale 1ns/1ps
module testbench;
  import prp_pkg::*;
  // ========
  // stimulus and bench model
  logic        clk_sys   = 1'b0;
  logic        sys_rst   = 1'b1;
  logic        cmd_valid = 1'b0;
  prp_op_t     cmd_op    = PRP_OP_READ;
  prp_mst_t    cmd_mst   = PRP_MST_CORE;
  logic        cmd_cfg   = 1'b0;
  logic        cmd_sup   = 1'b0;
  logic [31:0] cmd_addr  = 32'h0000_1000;
  logic [3:0]  cmd_be    = 4'hf;
  logic [31:0] cmd_data  = 32'h0000_0000;
  logic        cmd_ready, rsp_valid, wr_stb, ext_cycle;
  logic [31:0] rsp_data, r, wr_data;
  logic [8:0]  wr_idx;
  logic [3:0]  wr_be;
  logic [31:0] m [5];
  int          bad_count = 0, comparisons = 0, cycles = 0;
  int          stb_n = 0, exp_stb = 0;
  integer      seed = 32'h76193723;
  prp_bus_if bus ();
  always #5 clk_sys = ~clk_sys;

  prp_port prp_port_inst (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .bus(bus.port), .wr_stb(wr_stb), .wr_idx(wr_idx), .wr_data(wr_data),
    .wr_be(wr_be), .ext_cycle(ext_cycle));
  prp_master prp_master_inst (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_mst(cmd_mst),
    .cmd_cfg(cmd_cfg), .cmd_sup(cmd_sup), .cmd_addr(cmd_addr),
    .cmd_be(cmd_be), .cmd_data(cmd_data), .cmd_ready(cmd_ready),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .bus(bus.master));
  prp_assertions prp_assertions_inst (.clk_sys(clk_sys),
    .sys_rst(sys_rst), .req(bus.req), .we(bus.we), .lock(bus.lock),
    .cfg(bus.cfg), .addr(bus.addr), .rdata(bus.rdata),
    .ack(bus.ack), .fault(bus.fault));

  // cycle ceiling; a hang ends the run as a failure
  always @(posedge clk_sys) begin
    cycles++;
    if (wr_stb === 1'b1)
      stb_n++;
    if (cycles == 5000) begin
      bad_count++;
      stop_test();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // idx 0..4 id words, 5 reserved top word, 6 first word past window
  task automatic op_run(input prp_op_t op, input logic cfg,
                        input int idx, input logic [3:0] be,
                        input logic [31:0] d);
    logic [31:0] exp;
    int          n;
    exp = (idx < 5) ? m[idx] : 32'h0000_0000;
    @(negedge clk_sys);
    {cmd_valid, cmd_cfg, cmd_be, cmd_data} = {1'b1, cfg, be, d};
    cmd_sup = 1'($random(seed));
    cmd_op = op;
    cmd_mst = prp_mst_t'(1'($random(seed)));
    cmd_addr = (idx == 6) ? 32'h0000_1800 : (idx == 5) ?
               32'h0000_17fc : 32'h0000_1000 + 32'(idx) * 4;
    @(negedge clk_sys);
    cmd_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 20) begin
      @(negedge clk_sys);
      n++;
    end
    chk("done", 32'(rsp_valid), 32'(idx != 6));
    if (idx < 6 && op != PRP_OP_WRITE)
      chk("rdata", rsp_data, exp);
    chk("ext", 32'(ext_cycle), 32'h0);
    chk("ready", 32'(cmd_ready), 32'(idx != 6));
    if (idx < 5 && op == PRP_OP_RMW)
      m[idx] = d;
    for (int b = 0; b < 4; b++)
      if (idx < 5 && op == PRP_OP_WRITE && be[b])
        m[idx][8*b +: 8] = d[8*b +: 8];
    // write event toward the units keeps the last stored transfer
    if (idx < 5 && op != PRP_OP_READ) begin
      exp_stb++;
      chk("wr_idx", 32'(wr_idx), 32'(idx));
      chk("wr_data", wr_data, d);
      chk("wr_be", 32'(wr_be), (op == PRP_OP_RMW) ? 32'hf : 32'(be));
    end
  endtask : op_run

  // reset, then check every id word against its reset value
  task automatic do_reset;
    @(negedge clk_sys);
    sys_rst = 1'b1;
    repeat (5) @(negedge clk_sys);
    sys_rst = 1'b0;
    m = '{RST_VENDOR, RST_DEVICE, RST_REVISION, RST_CLASS, RST_HEADER};
    for (int i = 0; i < 5; i++)
      op_run(PRP_OP_READ, 1'($random(seed)), i, 4'($random(seed)), r);
  endtask : do_reset

  task automatic stop_test;
    if (bad_count == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : stop_test

  // ========
  // main sequence: random traffic, out-of-window hang, reset in flight
  initial begin
    do_reset();
    repeat (80) begin
      r = $random(seed);
      if (r[31:29] > 3'h5)
        op_run(r[8] ? PRP_OP_WRITE : PRP_OP_READ, 1'b1, 5, r[7:4],
               $random(seed));
      else
        op_run(prp_op_t'(2'(r[15:8] % 3)), r[16] | (r[31:29] == 3'h5),
               int'(r[31:29]), r[7:4], $random(seed));
    end
    op_run(PRP_OP_WRITE, 1'b0, 0, 4'hf, $random(seed));
    op_run(PRP_OP_READ, 1'b0, 0, 4'h0, r);
    op_run(PRP_OP_READ, 1'b0, 6, 4'hf, r);
    do_reset();
    chk("stb", 32'(stb_n), 32'(exp_stb));
    stop_test();
  end
endmodule : testbench
